// ### src/smon_pkg.sv
package smon_pkg;
  // Frame size and readback layouts; field positions follow the packed order.
  localparam int FRAME_BITS = 32;
  localparam int WR_CRC_BITS = 21;
  localparam int RD_CRC_BITS = 22;
  typedef struct packed {
    logic [4:0] dev;
    logic [5:0] reg_addr;
    logic [7:0] data;
    logic all;
    logic rsv;
    logic [7:0] crc;
    logic [2:0] pad;
  } wr_frame_t;
  typedef struct packed {
    logic [4:0] dev;
    logic [3:0] chan;
    logic [11:0] result;
    logic ack;
    logic [7:0] crc;
    logic [1:0] pad;
  } rd_conv_t;
  typedef struct packed {
    logic [4:0] dev;
    logic [5:0] reg_addr;
    logic [7:0] data;
    logic [1:0] zero;
    logic ack;
    logic [7:0] crc;
    logic [1:0] pad;
  } rd_reg_t;
  // One conversion result as it travels through the buffer.
  typedef struct packed {
    logic [3:0] chan;
    logic [11:0] result;
  } conv_t;
  // Register offsets.
  localparam logic [5:0] ADDR_BAL_FIRST = 6'h15;
  localparam logic [5:0] ADDR_PD = 6'h1b;
  localparam logic [5:0] ADDR_RB = 6'h1c;
  localparam logic [5:0] ADDR_GATE = 6'h1d;
  localparam int NUM_BAL = 6;
  // Field positions and reset values.
  localparam int CODE_LSB = 3;
  localparam int RB_LSB = 2;
  localparam int GATE_BIT = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [4:0] DEV_RESET = 5'h00;
  localparam logic [5:0] RB_CONV = 6'h00;
  // Check polynomial and start value; plain defaults.
  localparam logic [7:0] CRC_POLY = 8'h2f;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // Timing.
  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_S = 1000000000;
  localparam int STEP_S = 75;
  localparam int SEC_CYCLES = NS_PER_S / CLK_PERIOD_NS;
  localparam int FIFO_DEPTH = 8;
endpackage

// ### src/conv_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module conv_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_i, // Clock.
  input wire logic reset_n_i, // Synchronous reset, active low.
  input wire logic [WIDTH-1:0] in_data_i, // Write data.
  input wire logic in_valid_i, // Write request.
  output logic in_ready_o, // Room available.
  output logic [WIDTH-1:0] out_data_o, // Head word.
  output logic out_valid_o, // Head word valid.
  input wire logic out_ready_i // Pop request.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Handshakes honour full and empty.
  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_ready_i & out_valid_o;
  assign out_data_o = mem[rd_ptr];

  // Storage array.
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end

  // Pointers and fill level.
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // conv_fifo
`default_nettype wire

// ### src/stack_monitor_serial_cmd_port.sv
// Overview of operation
// - Balance timer code in bits 7..3.
// - Auto power-down after programmed 75 s steps.
// - Power-down, readback, gating registers reset zero.
// - Readback select zero returns conversion results.
// - Readback select address in bits 7..2.
// - Gating bit holds convert start high.
// - Sample input falling, drive output rising.
// - Chip select frames; may start conversions.
// - One 32-bit frame per register write.
// - Five-bit chain address, reset zero, lockable.
// - Device address travels LSB first.
// - Register addresses are six bits.
// - Write data field is eight bits.
// - Broadcast bit makes every device write.
// - Bad write check discards the command.
// - Readback frames carry address, data, ack, check.
// - Conversions read as consecutive frames.
// - Each result tagged with four-bit channel.
// - Addressing supports twenty chained devices.
// - Write check in bits 10..3, MSB first.
// - Readback check over 31..10 into 9..2.
// - Acknowledge bit reports previous write executed.
// - Response out while next command in.
`timescale 1ns/10ps
`default_nettype none
module stack_monitor_serial_cmd_port #(
  parameter int SEC_CYC = smon_pkg::SEC_CYCLES
) (
  input wire logic mclk_i, // System clock, 250 MHz.
  input wire logic reset_n_i, // Synchronous reset, active low.
  input wire logic cs_n_i, // Chip select pin, active low.
  input wire logic sclk_i, // Serial clock pin.
  input wire logic serial_data_in_i, // Serial command input.
  output logic serial_data_out_o, // Serial response output.
  input wire logic convert_start_n_i, // Convert start pin, active low.
  output logic convert_start_n_o, // Internal gated convert start, active low.
  input wire logic cs_convert_en_i, // Start conversions on chip select release.
  output logic cs_convert_o, // Conversion start pulse.
  input wire logic [4:0] dev_addr_i, // Chain position to take while unlocked.
  input wire logic addr_lock_i, // Freezes the chain address.
  output logic [4:0] device_addr_o, // Current chain address.
  input wire smon_pkg::conv_t conv_i, // Conversion result from the converter.
  input wire logic conv_valid_i, // Result valid.
  output logic conv_ready_o, // Buffer can take a result.
  output logic powerdown_o, // Power-down request.
  output logic [5:0] balance_active_o // Balance timer running per cell.
);
  import smon_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] prev;
  logic cs_s;
  logic sclk_s;
  logic sdi_s;
  logic cnv_s;
  logic sclk_fall;
  logic sclk_rise;
  logic cs_fall;
  logic cs_rise;
  logic [31:0] rx;
  logic [31:0] tx;
  logic [5:0] bit_cnt;
  logic [4:0] device_addr;
  logic write_ack;
  logic [7:0] powerdown_delay;
  logic [7:0] readback_select;
  logic [7:0] convert_start_gating;
  logic [7:0] balance_on_time [NUM_BAL];
  logic [4:0] bal_left [NUM_BAL];
  logic [4:0] pd_left;
  logic pd_run;
  logic [31:0] sec_cnt;
  logic [6:0] step_cnt;
  logic step_tick;
  wr_frame_t wf;
  logic [4:0] wf_dev;
  logic crc_ok;
  logic exec;
  logic [5:0] rb_addr;
  conv_t head;
  logic head_valid;
  logic pop;
  rd_conv_t next_conv;
  rd_reg_t next_reg;

  // Bit reversal for the address field that moves LSB first.
  function automatic logic [4:0] rev5(input logic [4:0] a);
    rev5 = {a[0], a[1], a[2], a[3], a[4]};
  endfunction

  // Serial check over the top nbits of a frame, MSB first.
  function automatic logic [7:0] crc8(input logic [31:0] w, input int nbits);
    logic [7:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = 0; i < FRAME_BITS; i++)
    begin
      if (i < nbits)
      begin
        fb = c[7] ^ w[31-i];
        c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
      end
    end
    crc8 = c;
  endfunction

  // Register read decode.
  function automatic logic [7:0] reg_read(input logic [5:0] a);
    reg_read = 8'h00;
    if (a >= ADDR_BAL_FIRST && a < ADDR_BAL_FIRST + 6'(NUM_BAL))
      reg_read = balance_on_time[3'(a - ADDR_BAL_FIRST)];
    else if (a == ADDR_PD)
      reg_read = powerdown_delay;
    else if (a == ADDR_RB)
      reg_read = readback_select;
    else if (a == ADDR_GATE)
      reg_read = convert_start_gating;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the second stage and its delayed copy are read.
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      sync1 <= 4'hf;
      sync2 <= 4'hf;
      prev <= 4'hf;
    end
    else
    begin
      sync1 <= {convert_start_n_i, serial_data_in_i, sclk_i, cs_n_i};
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  assign cs_s = sync2[0];
  assign sclk_s = sync2[1];
  assign sdi_s = sync2[2];
  assign cnv_s = sync2[3];
  assign sclk_fall = prev[1] & ~sclk_s & ~cs_s;
  assign sclk_rise = ~prev[1] & sclk_s & ~cs_s;
  assign cs_fall = prev[0] & ~cs_s;
  assign cs_rise = ~prev[0] & cs_s;

  ////////////////////////////////////////////////////////////////////////////
  // Receive shifter and bit counter.
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      rx <= '0;
      bit_cnt <= '0;
    end
    else if (cs_s)
      bit_cnt <= '0;
    else if (sclk_fall)
    begin
      rx <= {rx[30:0], sdi_s};
      if (bit_cnt != 6'(FRAME_BITS))
        bit_cnt <= bit_cnt + 6'h01;
    end
  end

  assign wf = wr_frame_t'(rx);
  assign wf_dev = rev5(wf.dev);
  assign crc_ok = (crc8(rx, WR_CRC_BITS) == wf.crc);
  assign exec = cs_rise && bit_cnt == 6'(FRAME_BITS) && crc_ok && (wf.all || wf_dev == device_addr);

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      write_ack <= 1'b0;
    else if (cs_rise && bit_cnt == 6'(FRAME_BITS))
      write_ack <= exec;
  end

  ////////////////////////////////////////////////////////////////////////////
  // twenty-device chain address
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      device_addr <= DEV_RESET;
    else if (!addr_lock_i)
      device_addr <= dev_addr_i;
  end

  assign device_addr_o = device_addr;

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      powerdown_delay <= REG_RESET;
      readback_select <= REG_RESET;
      convert_start_gating <= REG_RESET;
    end
    else if (exec)
    begin
      if (wf.reg_addr == ADDR_PD)
        powerdown_delay <= wf.data;
      if (wf.reg_addr == ADDR_RB)
        readback_select <= wf.data;
      if (wf.reg_addr == ADDR_GATE)
        convert_start_gating <= wf.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Step tick: one pulse every 75 seconds.
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      sec_cnt <= '0;
      step_cnt <= '0;
    end
    else if (sec_cnt == 32'(SEC_CYC - 1))
    begin
      sec_cnt <= '0;
      step_cnt <= (step_cnt == 7'(STEP_S - 1)) ? '0 : step_cnt + 7'h01;
    end
    else
      sec_cnt <= sec_cnt + 32'h1;
  end

  assign step_tick = (sec_cnt == 32'(SEC_CYC - 1)) && (step_cnt == 7'(STEP_S - 1));

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      pd_left <= '0;
      pd_run <= 1'b0;
      powerdown_o <= 1'b0;
    end
    else if (exec && wf.reg_addr == ADDR_PD)
    begin
      pd_left <= wf.data[7:CODE_LSB];
      pd_run <= (wf.data[7:CODE_LSB] != 5'h00);
      powerdown_o <= step_tick && pd_run && (pd_left == 5'h01); // An expiry in the same cycle still wins.
    end
    else if (step_tick && pd_run)
    begin
      pd_left <= pd_left - 5'h01;
      if (pd_left == 5'h01)
      begin
        pd_run <= 1'b0;
        powerdown_o <= 1'b1;
      end
    end
  end

  for (genvar i = 0; i < NUM_BAL; i++)
  begin : g_bal
    always_ff @(posedge mclk_i)
    begin
      if (!reset_n_i)
      begin
        balance_on_time[i] <= REG_RESET;
        bal_left[i] <= '0;
      end
      else if (exec && wf.reg_addr == ADDR_BAL_FIRST + 6'(i))
      begin
        balance_on_time[i] <= wf.data;
        bal_left[i] <= wf.data[7:CODE_LSB];
      end
      else if (step_tick && bal_left[i] != 5'h00)
        bal_left[i] <= bal_left[i] - 5'h01;
    end
    assign balance_active_o[i] = (bal_left[i] != 5'h00);
  end

  ////////////////////////////////////////////////////////////////////////////
  // convert start gating
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      convert_start_n_o <= 1'b1;
    else
      convert_start_n_o <= convert_start_gating[GATE_BIT] | cnv_s;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      cs_convert_o <= 1'b0;
    else
      cs_convert_o <= cs_rise & cs_convert_en_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // result buffer
  conv_fifo #(
    .WIDTH($bits(conv_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .in_data_i(conv_i),
    .in_valid_i(conv_valid_i),
    .in_ready_o(conv_ready_o),
    .out_data_o(head),
    .out_valid_o(head_valid),
    .out_ready_i(pop)
  );

  assign rb_addr = readback_select[7:RB_LSB];
  assign pop = cs_fall && rb_addr == RB_CONV;

  always_comb
  begin
    next_conv = '0;
    next_conv.dev = rev5(device_addr);
    next_conv.chan = head_valid ? head.chan : 4'h0;
    next_conv.result = head_valid ? head.result : 12'h000;
    next_conv.ack = write_ack;
    next_conv.crc = crc8(32'(next_conv), RD_CRC_BITS);
  end

  always_comb
  begin
    next_reg = '0;
    next_reg.dev = rev5(device_addr);
    next_reg.reg_addr = rb_addr;
    next_reg.data = reg_read(rb_addr);
    next_reg.ack = write_ack;
    next_reg.crc = crc8(32'(next_reg), RD_CRC_BITS);
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
      tx <= '0;
    else if (cs_fall)
      tx <= (rb_addr == RB_CONV) ? 32'(next_conv) : 32'(next_reg);
    else if (sclk_rise)
      tx <= {tx[30:0], 1'b0};
  end

  assign serial_data_out_o = tx[31];
endmodule // stack_monitor_serial_cmd_port
`default_nettype wire

// ### dv/smon_chk.sv
`timescale 1ns/10ps
`default_nettype none
module smon_chk (
  input wire logic mclk_i, // Clock.
  input wire logic reset_n_i, // Reset.
  input wire logic cs_n_i, // Select.
  input wire logic sclk_i, // Link clock.
  input wire logic serial_data_out_o, // Response.
  input wire logic convert_start_n_i, // Start pin.
  input wire logic convert_start_n_o, // Gated start.
  input wire logic cs_convert_en_i, // Start enable.
  input wire logic cs_convert_o, // Start pulse.
  input wire logic [4:0] dev_addr_i, // Address pins.
  input wire logic addr_lock_i, // Lock.
  input wire logic [4:0] device_addr_o, // Address.
  input wire logic conv_ready_o, // Room.
  input wire logic powerdown_o, // Power-down.
  input wire logic [5:0] balance_active_o // Timers.
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);
  // Timing relations between the pins and the outputs.
  AST_ADDR_LOAD: assert property (!addr_lock_i |=> device_addr_o == $past(dev_addr_i))
    else $error("address not loaded");
  AST_ADDR_HOLD: assert property (addr_lock_i |=> $stable(device_addr_o))
    else $error("locked address moved");
  AST_CSC_PULSE: assert property (cs_convert_o |=> !cs_convert_o)
    else $error("start pulse too long");
  AST_CSC_CAUSE: assert property (cs_convert_o |-> cs_n_i && $past(cs_n_i, 2) && cs_convert_en_i)
    else $error("start pulse without release");
  AST_SDO_IDLE: assert property ((cs_n_i && sclk_i) [*6] |=> $stable(serial_data_out_o))
    else $error("response moved while idle");
  AST_SDO_FALL: assert property ($fell(sclk_i) && !cs_n_i |=> $stable(serial_data_out_o) [*6])
    else $error("response moved after falling edge");
  AST_GATE_IDLE: assert property (convert_start_n_i [*8] |=> convert_start_n_o)
    else $error("start low without pin");
  AST_PD_CLEAR: assert property ($fell(powerdown_o) |-> cs_n_i)
    else $error("power-down cleared inside frame");
  AST_BAL_START: assert property ($rose(|balance_active_o) |-> cs_n_i)
    else $error("timer started inside frame");
  COV_CSC: cover property (cs_convert_o);
  COV_PD: cover property ($rose(powerdown_o));
  COV_FULL: cover property (!conv_ready_o);
endmodule // smon_chk
bind stack_monitor_serial_cmd_port smon_chk u_smon_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
  .cs_n_i(cs_n_i), .sclk_i(sclk_i), .serial_data_out_o(serial_data_out_o),
  .convert_start_n_i(convert_start_n_i), .convert_start_n_o(convert_start_n_o),
  .cs_convert_en_i(cs_convert_en_i), .cs_convert_o(cs_convert_o), .dev_addr_i(dev_addr_i),
  .addr_lock_i(addr_lock_i), .device_addr_o(device_addr_o), .conv_ready_o(conv_ready_o),
  .powerdown_o(powerdown_o), .balance_active_o(balance_active_o));
`default_nettype wire

// ### dv/smon_host.sv
`timescale 1ns/10ps
`default_nettype none
module smon_host (
  input wire logic clk_i, // Bench clock.
  input wire logic sdo_i, // Response bit.
  output var logic cs_n_o = 1'b1, // Frame select.
  output var logic sclk_o = 1'b1, // Link clock, idle high.
  output var logic sdi_o = 1'b0 // Command bit.
);
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    logic [31:0] sh;
    sh = tx;
    rx = 32'h0;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    sdi_o <= sh[31];
    for (int i = 31; i > 31 - n; i--)
    begin
      repeat (10) @(posedge clk_i);
      sclk_o <= 1'b0;
      rx[i] = sdo_i;
      sh = sh << 1;
      repeat (10) @(posedge clk_i);
      sclk_o <= 1'b1;
      sdi_o <= sh[31];
    end
    repeat (10) @(posedge clk_i);
    cs_n_o <= 1'b1;
    sdi_o <= ~sh[31];
    repeat (20) @(posedge clk_i);
  endtask
endmodule // smon_host
`default_nettype wire

// ### dv/tb_stack_monitor_serial_cmd_port.sv
`timescale 1ns/10ps
`default_nettype none
module tb_stack_monitor_serial_cmd_port;
  import smon_pkg::*;
  logic mclk_i;
  logic reset_n_i = 1'b0;
  logic cs_n, sclk, sdi, sdo, cst_n_o, csc, pd, crdy;
  logic cst_n_i = 1'b1;
  logic csc_en = 1'b0;
  logic lock = 1'b0;
  logic cvalid = 1'b0;
  logic [4:0] dev_pin = 5'h00;
  logic [4:0] dev_o;
  logic [4:0] my_dev = 5'h00;
  logic [5:0] bal;
  logic [31:0] rx;
  conv_t conv = '0;
  int bad_count = 0;
  int n_checks = 0;
  int pulses = 0;
  stack_monitor_serial_cmd_port #(.SEC_CYC(10)) u_stack_monitor_serial_cmd_port (.mclk_i(mclk_i),
    .reset_n_i(reset_n_i), .cs_n_i(cs_n), .sclk_i(sclk), .serial_data_in_i(sdi), .serial_data_out_o(sdo),
    .convert_start_n_i(cst_n_i), .convert_start_n_o(cst_n_o), .cs_convert_en_i(csc_en), .cs_convert_o(csc),
    .dev_addr_i(dev_pin), .addr_lock_i(lock), .device_addr_o(dev_o), .conv_i(conv), .conv_valid_i(cvalid),
    .conv_ready_o(crdy), .powerdown_o(pd), .balance_active_o(bal));
  smon_host u_smon_host (.clk_i(mclk_i), .sdo_i(sdo), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));
  ////////////////////
  // Clock, watchdog and start pulse counter.
  initial
  begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  initial
  begin
    #300000;
    bad_count++;
    close_out();
  end
  always @(posedge mclk_i)
    if (csc === 1'b1)
      pulses <= pulses + 1;
  ////////////////////
  // frame check codes
  function automatic logic [7:0] crc8(input logic [31:0] w, input int n);
    logic [7:0] c = CRC_INIT;
    for (int i = 31; i > 31 - n; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction
  function automatic logic [31:0] wr(input logic [4:0] d, input logic [5:0] a, input logic [7:0] v,
                                     input logic all);
    logic [31:0] w = {d[0], d[1], d[2], d[3], d[4], a, v, all, 1'b0, 11'h000};
    w[10:3] = crc8(w, 21);
    return w;
  endfunction
  function automatic logic [31:0] rsp(input logic [16:0] b);
    logic [31:0] w = {my_dev[0], my_dev[1], my_dev[2], my_dev[3], my_dev[4], b, 10'h000};
    w[9:2] = crc8(w, 22);
    return w;
  endfunction
  function automatic conv_t cv(input int i);
    return {4'(i + 1), 12'(12'h9a0 + i)};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic sendf(input logic [31:0] tx);
    u_smon_host.xfer(tx, 32, rx);
  endtask
  task automatic wreg(input logic [5:0] a, input logic [7:0] v);
    sendf(wr(my_dev, a, v, 1'b0));
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] v);
    sendf(wr(my_dev, ADDR_RB, {a, 2'b00}, 1'b0));
    sendf(wr(my_dev, ADDR_RB, {a, 2'b00}, 1'b0));
    check(rx, rsp({a, v, 3'b001}));
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////
  // Main sequence.
  initial
  begin
    repeat (5) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    for (int i = 0; i < 9; i++)
    begin
      conv <= cv(i);
      cvalid <= 1'b1;
      @(posedge mclk_i);
    end
    cvalid <= 1'b0;
    @(posedge mclk_i);
    check(32'(crdy), 32'h0);
    for (int i = 0; i < 9; i++)
    begin
      sendf(32'h0);
      check(rx, rsp({(i < 8) ? cv(i) : 16'h0, i > 0}));
    end
    rd(ADDR_PD, 8'h00);
    rd(ADDR_GATE, 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      wreg(6'(ADDR_BAL_FIRST + i), {5'(i + 1), 3'b000});
      rd(6'(ADDR_BAL_FIRST + i), {5'(i + 1), 3'b000});
    end
    cst_n_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    check(32'(cst_n_o), 32'h0);
    wreg(ADDR_GATE, 8'h01);
    check(32'(cst_n_o), 32'h1);
    rd(ADDR_GATE, 8'h01);
    wreg(ADDR_GATE, 8'h00);
    check(32'(cst_n_o), 32'h0);
    cst_n_i <= 1'b1;
    wreg(ADDR_PD, 8'h10);
    rd(ADDR_PD, 8'h10);
    sendf(wr(my_dev, ADDR_PD, 8'h08, 1'b0) ^ 32'h8);
    u_smon_host.xfer(wr(my_dev, ADDR_PD, 8'h08, 1'b0), 20, rx);
    sendf(wr(my_dev, ADDR_RB, {ADDR_PD, 2'b00}, 1'b0));
    check(rx, rsp({ADDR_PD, 8'h10, 3'b000}));
    dev_pin <= 5'h13;
    repeat (3) @(posedge mclk_i);
    lock <= 1'b1;
    dev_pin <= 5'h0a;
    repeat (3) @(posedge mclk_i);
    check(32'(dev_o), 32'h13);
    csc_en <= 1'b1;
    my_dev = 5'h03;
    wreg(ADDR_GATE, 8'h01);
    csc_en <= 1'b0;
    check(32'(pulses), 32'h1);
    my_dev = 5'h13;
    rd(ADDR_GATE, 8'h00);
    sendf(wr(5'h00, ADDR_GATE, 8'h01, 1'b1));
    rd(ADDR_GATE, 8'h01);
    wreg(ADDR_BAL_FIRST, 8'h10);
    check(32'(bal[0]), 32'h1);
    wreg(ADDR_PD, 8'h18);
    repeat (1400) @(posedge mclk_i);
    check({25'h0, pd, bal}, 32'h0);
    repeat (900) @(posedge mclk_i);
    check(32'(pd), 32'h1);
    close_out();
  end
endmodule // tb_stack_monitor_serial_cmd_port
`default_nettype wire
